// ---- rtl/dca_consts.svh ----
`ifndef DCA_CONSTS_SVH
`define DCA_CONSTS_SVH
// Register byte offsets
`define DCA_A_CTRL3 8'h0C
`define DCA_A_PRIO_SET 8'h10
`define DCA_A_PRIO_CLR 8'h14
`define DCA_A_SW_REQ 8'h18
`define DCA_A_CH_EN 8'h1C
`define DCA_A_FLAGS 8'h20
`define DCA_A_BASE 8'h24
`define DCA_A_STATUS 8'h28
// Channel source control fields
`define DCA_F_SRCSEL 3:0
`define DCA_F_REQUEST_SIGNAL_SELECT 9:8
`define DCA_B_SREQ_EN 16
`define DCA_CTRL_MASK 32'h0001_030F
// Descriptor layout
`define DCA_D_SRC 32'h0000_0000
`define DCA_D_DST 32'h0000_0004
`define DCA_D_CTRL 32'h0000_0008
`define DCA_F_CYC 2:0
`define DCA_F_NM1 13:4
`define DCA_F_RPOW 17:14
`define DCA_CYC_INVALID 3'h0
`define DCA_CYC_BASIC 3'h1
`define DCA_CYC_AUTO 3'h2
`define DCA_CYC_PINGPONG 3'h3
`define DCA_CYC_MSG_PRI 3'h4
`define DCA_CYC_MSG_ALT 3'h5
`define DCA_CYC_PSG_PRI 3'h6
`define DCA_CYC_PSG_ALT 3'h7
// Arbitration interval
`define DCA_RPOW_MAX 4'h9
`define DCA_BURST_CAP 11'h400
`define DCA_XFER_STEP 32'h0000_0004
// AXI responses
`define DCA_RESP_OK 2'h0
`define DCA_RESP_ERR 2'h2
`endif

// ---- rtl/dca_pkg.sv ----
package dca_pkg;
  typedef enum logic [2:0] {
    ST_ARB, ST_FETCH, ST_RD, ST_WR, ST_WB
  } dca_state_e;
  typedef enum logic [2:0] {
    MODE_INVALID, MODE_BASIC, MODE_AUTO, MODE_PINGPONG, MODE_MEM_SG,
    MODE_PER_SG
  } dca_mode_e;
endpackage : dca_pkg

// ---- rtl/dca_regs.sv ----
`timescale 1ns/1ns
`include "dca_consts.svh"
module dca_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  output logic [3:0][31:0] ctrl_q,
  output logic [3:0] prio_q,
  output logic [3:0] en_q,
  output logic [31:0] base_q,
  output logic [3:0] trig_q,
  output logic [3:0] cwr_q,
  output logic [3:0] fclr_q,
  input wire logic [3:0] flags,
  input wire logic [31:0] status
);
  logic awh_q, awh_d, wh_q, wh_d, bv_d, rv_d, awr_d, wr_d, arr_d;
  logic [7:0] aw_q, aw_d;
  logic [31:0] w_q, w_d, rd_d, base_d;
  logic [3:0] ws_q, ws_d, prio_d, en_d, trig_d, cwr_d, fclr_d;
  logic [1:0] br_d, rr_d;
  logic [3:0][31:0] ctrl_d;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction : merge

  always_comb begin
    {awh_d, aw_d, wh_d, w_d, ws_d} = {awh_q, aw_q, wh_q, w_q, ws_q};
    {bv_d, br_d, rv_d, rd_d, rr_d} = {bvalid, bresp, rvalid, rdata, rresp};
    {ctrl_d, prio_d, en_d, base_d} = {ctrl_q, prio_q, en_q, base_q};
    {trig_d, cwr_d, fclr_d} = '0;
    if (awvalid && awready) begin
      awh_d = 1'b1;
      aw_d = awaddr;
    end
    if (wvalid && wready) begin
      wh_d = 1'b1;
      w_d = wdata;
      ws_d = wstrb;
    end
    if (bvalid && bready) bv_d = 1'b0;
    if (awh_q && wh_q && !bvalid) begin
      awh_d = 1'b0;
      wh_d = 1'b0;
      bv_d = 1'b1;
      br_d = `DCA_RESP_OK;
      if (aw_q <= `DCA_A_CTRL3 && aw_q[1:0] == 2'h0) begin
        ctrl_d[aw_q[3:2]] = merge(ctrl_q[aw_q[3:2]], w_q, ws_q) &
                            `DCA_CTRL_MASK;
        cwr_d[aw_q[3:2]] = 1'b1;
      end else begin
        case (aw_q)
          `DCA_A_PRIO_SET: prio_d = prio_q | w_q[3:0];
          `DCA_A_PRIO_CLR: prio_d = prio_q & ~w_q[3:0];
          `DCA_A_SW_REQ: trig_d = w_q[3:0];
          `DCA_A_CH_EN: en_d = w_q[3:0];
          `DCA_A_FLAGS: fclr_d = w_q[3:0];
          `DCA_A_BASE: base_d = merge(base_q, w_q, ws_q);
          `DCA_A_STATUS: br_d = `DCA_RESP_OK;
          default: br_d = `DCA_RESP_ERR;
        endcase
      end
    end
    if (rvalid && rready) rv_d = 1'b0;
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rr_d = `DCA_RESP_OK;
      rd_d = '0;
      if (araddr <= `DCA_A_CTRL3 && araddr[1:0] == 2'h0) begin
        rd_d = ctrl_q[araddr[3:2]];
      end else begin
        case (araddr)
          `DCA_A_PRIO_SET, `DCA_A_PRIO_CLR: rd_d = {28'h0, prio_q};
          `DCA_A_SW_REQ: rd_d = '0;
          `DCA_A_CH_EN: rd_d = {28'h0, en_q};
          `DCA_A_FLAGS: rd_d = {28'h0, flags};
          `DCA_A_BASE: rd_d = base_q;
          `DCA_A_STATUS: rd_d = status;
          default: rr_d = `DCA_RESP_ERR;
        endcase
      end
    end
    awr_d = !awh_d && !bv_d;
    wr_d = !wh_d && !bv_d;
    arr_d = !rv_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awh_q, aw_q, wh_q, w_q, ws_q} <= '0;
      {bvalid, bresp, rvalid, rdata, rresp} <= '0;
      {awready, wready, arready} <= '0;
      {ctrl_q, prio_q, en_q, base_q} <= '0;
      {trig_q, cwr_q, fclr_q} <= '0;
    end else begin
      {awh_q, aw_q, wh_q, w_q, ws_q} <= {awh_d, aw_d, wh_d, w_d, ws_d};
      {bvalid, bresp, rvalid, rdata, rresp} <= {bv_d, br_d, rv_d, rd_d, rr_d};
      {awready, wready, arready} <= {awr_d, wr_d, arr_d};
      {ctrl_q, prio_q, en_q, base_q} <= {ctrl_d, prio_d, en_d, base_d};
      {trig_q, cwr_q, fclr_q} <= {trig_d, cwr_d, fclr_d};
    end
  end
endmodule : dca_regs

// ---- rtl/dca_top.sv ----
`timescale 1ns/1ns
`include "dca_consts.svh"
// Summary of operation
// - Four channels, each mapped to any source
// - Software can trigger every channel
// - Fetch descriptor first, then do transfers
// - Source, destination, count come from descriptor
// - Control holds source and signal select
// - Burst request runs two-power-exponent transfers
// - Enabled single-only request runs one transfer
// - Every peripheral bursts; some also single
// - Exponent 0-9 power of two, else 1024
// - Full intervals first, leftover at end
// - Exponent read from descriptor control word
// - Arbitrate on channel number and level
// - High level first; lower number wins
// - Poll all channels after each interval
// - Decode invalid, basic, auto, ping-pong
// - Decode memory and peripheral scatter-gather
// - Cycle type read from descriptor word
// - Finished cycle written back as invalid
// - Completion pulse lasts one clock
module dca_top #(
  parameter int NREQ = 64
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral request lines
  input wire logic [NREQ-1:0] periph_burst_req,
  input wire logic [NREQ-1:0] periph_single_req,
  // System memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Completion
  output logic [3:0] chan_done
);
  logic [3:0][31:0] ctrl;
  logic [3:0] prio, en, trig, cwr, fclr;
  logic [31:0] base;
  logic [NREQ-1:0] bm_q, bs_q, sm_q, ss_q;
  logic [3:0] want, bw, flag_q, flag_d, swp_q, swp_d;
  logic [3:0] loaded_q, loaded_d, dead_q, dead_d, auto_q, auto_d, done_d;
  logic [31:0] src_q [4], src_d [4], dst_q [4], dst_d [4];
  logic [31:0] cw_q [4], cw_d [4];
  logic [10:0] left_q [4], left_d [4], bcnt_q, bcnt_d, nleft;
  logic [3:0] rpow_q [4], rpow_d [4];
  logic [1:0] cur_q, cur_d, widx_q, widx_d;
  logic [31:0] data_q, data_d, maddr_d, mwdata_d;
  logic mreq_d, mwe_d, bmode_q, bmode_d;
  logic [2:0] g;
  logic [31:0] woff;
  dca_pkg::dca_state_e st_q, st_d;
  dca_pkg::dca_mode_e mode;

  dca_regs u_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
    .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready),
    .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready), .ctrl_q(ctrl), .prio_q(prio), .en_q(en),
    .base_q(base), .trig_q(trig), .cwr_q(cwr), .fclr_q(fclr),
    .flags(flag_q),
    .status({16'h0, dead_q, loaded_q, 5'h0, st_q != dca_pkg::ST_ARB,
             cur_q})
  );

  function automatic logic [10:0] pw(input logic [3:0] r);
    return (r > `DCA_RPOW_MAX) ? `DCA_BURST_CAP : 11'(11'h1 << r);
  endfunction : pw

  function automatic logic [10:0] lmin(input logic [10:0] a,
      input logic [10:0] b);
    return (a < b) ? a : b;
  endfunction : lmin

  function automatic logic [31:0] daddr(input logic [31:0] b,
      input logic [1:0] c, input logic [31:0] off);
    return b + {26'h0, c, 4'h0} + off;
  endfunction : daddr

  function automatic dca_pkg::dca_mode_e decode(input logic [2:0] c);
    case (c)
      `DCA_CYC_BASIC: return dca_pkg::MODE_BASIC;
      `DCA_CYC_AUTO: return dca_pkg::MODE_AUTO;
      `DCA_CYC_PINGPONG: return dca_pkg::MODE_PINGPONG;
      `DCA_CYC_MSG_PRI, `DCA_CYC_MSG_ALT: return dca_pkg::MODE_MEM_SG;
      `DCA_CYC_PSG_PRI, `DCA_CYC_PSG_ALT: return dca_pkg::MODE_PER_SG;
      default: return dca_pkg::MODE_INVALID;
    endcase
  endfunction : decode

  // Two-stage synchronisers on every request pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {bm_q, bs_q, sm_q, ss_q} <= '0;
    end else begin
      bm_q <= periph_burst_req;
      bs_q <= bm_q;
      sm_q <= periph_single_req;
      ss_q <= sm_q;
    end
  end

  always_comb begin
    logic [3:0] m;
    logic [5:0] ix;
    m = 4'h0;
    ix = 6'h0;
    for (int c = 0; c < 4; c++) begin
      ix = {ctrl[c][`DCA_F_SRCSEL], ctrl[c][`DCA_F_REQUEST_SIGNAL_SELECT]};
      bw[c] = bs_q[ix] | swp_q[c] | auto_q[c];
      want[c] = en[c] & !dead_q[c] & (bw[c] |
                (ss_q[ix] & ctrl[c][`DCA_B_SREQ_EN]));
    end
    // High level masks default level; lowest index wins inside a level
    m = ((want & prio) != 4'h0) ? (want & prio) : want;
    g = 3'h0;
    for (int i = 3; i >= 0; i--) if (m[i]) g = {1'b1, 2'(i)};
  end

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    bcnt_d = bcnt_q;
    bmode_d = bmode_q;
    widx_d = widx_q;
    data_d = data_q;
    mreq_d = mem_req & !mem_ack;
    mwe_d = mem_we;
    maddr_d = mem_addr;
    mwdata_d = mem_wdata;
    done_d = '0;
    src_d = src_q;
    dst_d = dst_q;
    cw_d = cw_q;
    left_d = left_q;
    rpow_d = rpow_q;
    loaded_d = loaded_q;
    auto_d = auto_q;
    swp_d = swp_q;
    dead_d = dead_q & ~cwr;
    mode = decode(mem_rdata[`DCA_F_CYC]);
    nleft = left_q[cur_q] - 11'h1;
    woff = {28'h0, widx_q, 2'h0};
    case (st_q)
      dca_pkg::ST_ARB: begin
        if (g[2]) begin
          cur_d = g[1:0];
          bmode_d = bw[g[1:0]];
          swp_d[g[1:0]] = 1'b0;
          if (!loaded_q[g[1:0]]) begin
            st_d = dca_pkg::ST_FETCH;
            widx_d = 2'h0;
          end else begin
            bcnt_d = bw[g[1:0]] ? lmin(pw(rpow_q[g[1:0]]),
                     left_q[g[1:0]]) : 11'h1;
            st_d = dca_pkg::ST_RD;
          end
        end
      end
      dca_pkg::ST_FETCH: begin
        if (!mem_req) begin
          mreq_d = 1'b1;
          mwe_d = 1'b0;
          maddr_d = daddr(base, cur_q, {28'h0, widx_q, 2'h0});
        end
        if (mem_ack) begin
          widx_d = widx_q + 2'h1;
          if (woff == `DCA_D_SRC) src_d[cur_q] = mem_rdata;
          if (woff == `DCA_D_DST) dst_d[cur_q] = mem_rdata;
          if (woff == `DCA_D_CTRL) begin
            st_d = dca_pkg::ST_ARB;
            if (mode == dca_pkg::MODE_INVALID) begin
              dead_d[cur_q] = 1'b1;
            end else begin
              cw_d[cur_q] = mem_rdata;
              rpow_d[cur_q] = mem_rdata[`DCA_F_RPOW];
              left_d[cur_q] = {1'b0, mem_rdata[`DCA_F_NM1]} + 11'h1;
              loaded_d[cur_q] = 1'b1;
              // One request carries the whole cycle in these modes
              auto_d[cur_q] = mode == dca_pkg::MODE_AUTO ||
                              mode == dca_pkg::MODE_MEM_SG;
              bcnt_d = bmode_q ? lmin(pw(mem_rdata[`DCA_F_RPOW]),
                       {1'b0, mem_rdata[`DCA_F_NM1]} + 11'h1) : 11'h1;
              st_d = dca_pkg::ST_RD;
            end
          end
        end
      end
      dca_pkg::ST_RD: begin
        if (!mem_req) begin
          mreq_d = 1'b1;
          mwe_d = 1'b0;
          maddr_d = src_q[cur_q];
        end
        if (mem_ack) begin
          data_d = mem_rdata;
          st_d = dca_pkg::ST_WR;
        end
      end
      dca_pkg::ST_WR: begin
        if (!mem_req) begin
          mreq_d = 1'b1;
          mwe_d = 1'b1;
          maddr_d = dst_q[cur_q];
          mwdata_d = data_q;
        end
        if (mem_ack) begin
          src_d[cur_q] = src_q[cur_q] + `DCA_XFER_STEP;
          dst_d[cur_q] = dst_q[cur_q] + `DCA_XFER_STEP;
          left_d[cur_q] = nleft;
          bcnt_d = bcnt_q - 11'h1;
          if (nleft == 11'h0) st_d = dca_pkg::ST_WB;
          else if (bcnt_q == 11'h1) st_d = dca_pkg::ST_ARB;
          else st_d = dca_pkg::ST_RD;
        end
      end
      dca_pkg::ST_WB: begin
        if (!mem_req) begin
          mreq_d = 1'b1;
          mwe_d = 1'b1;
          maddr_d = daddr(base, cur_q, `DCA_D_CTRL);
          mwdata_d = {cw_q[cur_q][31:3], `DCA_CYC_INVALID};
        end
        if (mem_ack) begin
          done_d[cur_q] = 1'b1;
          loaded_d[cur_q] = 1'b0;
          auto_d[cur_q] = 1'b0;
          st_d = dca_pkg::ST_ARB;
        end
      end
      default: st_d = dca_pkg::ST_ARB;
    endcase
    swp_d = swp_d | trig;
    flag_d = (flag_q & ~fclr) | done_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= dca_pkg::ST_ARB;
      {cur_q, bcnt_q, bmode_q, widx_q, data_q} <= '0;
      {mem_req, mem_we, mem_addr, mem_wdata, chan_done} <= '0;
      {loaded_q, auto_q, swp_q, dead_q, flag_q} <= '0;
      for (int c = 0; c < 4; c++) begin
        {src_q[c], dst_q[c], cw_q[c], left_q[c], rpow_q[c]} <= '0;
      end
    end else begin
      st_q <= st_d;
      {cur_q, bcnt_q, bmode_q, widx_q, data_q} <=
        {cur_d, bcnt_d, bmode_d, widx_d, data_d};
      {mem_req, mem_we, mem_addr, mem_wdata, chan_done} <=
        {mreq_d, mwe_d, maddr_d, mwdata_d, done_d};
      {loaded_q, auto_q, swp_q, dead_q, flag_q} <=
        {loaded_d, auto_d, swp_d, dead_d, flag_d};
      src_q <= src_d;
      dst_q <= dst_d;
      cw_q <= cw_d;
      left_q <= left_d;
      rpow_q <= rpow_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_done_pulse;
    (chan_done != 4'h0) |=> (chan_done == 4'h0);
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse longer than one cycle");

  property p_done_after_wb;
    (chan_done != 4'h0) |-> $past(st_q == dca_pkg::ST_WB && mem_ack);
  endproperty
  a_done_after_wb: assert property (p_done_after_wb)
    else $error("completion without descriptor write-back");

  property p_wb_invalid;
    (st_q == dca_pkg::ST_WB && mem_req) |->
      (mem_we && mem_wdata[`DCA_F_CYC] == `DCA_CYC_INVALID);
  endproperty
  a_wb_invalid: assert property (p_wb_invalid)
    else $error("write-back does not mark cycle invalid");

  property p_flag;
    (chan_done != 4'h0) |-> ((flag_q & chan_done) == chan_done);
  endproperty
  a_flag: assert property (p_flag)
    else $error("completion not latched into flag");

  property p_fetch_first;
    (st_q == dca_pkg::ST_ARB && g[2] && !loaded_q[g[1:0]]) |=>
      (st_q == dca_pkg::ST_FETCH && !mem_req) ##1 (mem_req && !mem_we);
  endproperty
  a_fetch_first: assert property (p_fetch_first)
    else $error("unloaded channel did not fetch descriptor");

  property p_src_addr;
    (st_q == dca_pkg::ST_RD && mem_req) |-> mem_addr == src_q[cur_q];
  endproperty
  a_src_addr: assert property (p_src_addr)
    else $error("read not from descriptor source address");

  property p_single;
    (st_q == dca_pkg::ST_ARB && g[2] && loaded_q[g[1:0]] && !bw[g[1:0]])
      |=> bcnt_q == 11'h1;
  endproperty
  a_single: assert property (p_single)
    else $error("single request not exactly one transfer");

  property p_burst;
    (st_q == dca_pkg::ST_ARB && g[2] && loaded_q[g[1:0]] && bw[g[1:0]])
      |=> bcnt_q == lmin(pw(rpow_q[cur_q]), left_q[cur_q]);
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst length differs from arbitration interval");

  property p_prio;
    (st_q == dca_pkg::ST_ARB && (want & prio) != 4'h0) |=>
      (st_q != dca_pkg::ST_ARB && prio[cur_q]);
  endproperty
  a_prio: assert property (p_prio)
    else $error("default channel won over high channel");

  property p_dead;
    (st_q != dca_pkg::ST_ARB) |-> !dead_q[cur_q];
  endproperty
  a_dead: assert property (p_dead)
    else $error("invalid channel still arbitrating");

  property p_rearb;
    (st_q == dca_pkg::ST_WR && mem_ack && bcnt_q == 11'h1 &&
     left_q[cur_q] != 11'h1) |=> st_q == dca_pkg::ST_ARB;
  endproperty
  a_rearb: assert property (p_rearb)
    else $error("no re-arbitration after interval");

  c_done: cover property (chan_done != 4'h0);
  c_fetch: cover property (st_q == dca_pkg::ST_FETCH && mem_ack);
  c_high: cover property (st_q == dca_pkg::ST_ARB && g[2] && prio[g[1:0]]);
endmodule : dca_top

// ---- tb/dca_mem_model.sv ----
`timescale 1ns/1ns
// System memory seen by the master port; answers after lat extra cycles
module dca_mem_model (
  // Clock
  input wire logic aclk,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay
  input wire logic [3:0] lat
);
  logic [31:0] mem [0:63];
  logic [3:0] cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    cnt = 4'h0;
  end
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    // Read data toggles outside the ack so a stale sample shows up
    mem_rdata <= ~mem_rdata;
    // No second ack while the request of the last one drops
    if (mem_req && !mem_ack) begin
      if (cnt >= lat) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          mem[mem_addr[7:2]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[7:2]];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : dca_mem_model

// ---- tb/dca_top_bench.sv ----
`timescale 1ns/1ns
`include "dca_consts.svh"
module dca_top_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, mem_req, mem_we, mem_ack;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [3:0] s_axi_wstrb, chan_done, lat;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] periph_burst_req, periph_single_req;
  int failures;
  int checks;
  dca_top #(.NREQ(64)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .periph_burst_req, .periph_single_req, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .chan_done);
  dca_mem_model u_mem (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .lat);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic hang();
    chk(32'h0, 32'h1);
    final_report();
  endtask : hang
  // bready and rready stay high, so one edge never sees them set twice
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = `DCA_RESP_OK);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axr
  task automatic wdone(input int c);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge aclk);
      if (chan_done[c]) break;
    end
    if (n == 3000) hang();
    @(posedge aclk);
    chk({31'h0, chan_done[c]}, 32'h0);
  endtask : wdone
  // Word indices for s and d; the model keeps the last data word index 63
  task automatic desc(input int c, input int s, input int d, input int n,
      input int r, input logic [2:0] y);
    u_mem.mem[c*4] = 32'(s * 4);
    u_mem.mem[c*4+1] = 32'(d * 4);
    u_mem.mem[c*4+2] = 32'((r << 14) | ((n - 1) << 4)) | {29'h0, y};
  endtask : desc
  task automatic cpy(input int c, input int s, input int d, input int n);
    for (int i = 0; i < n; i++) begin
      chk(u_mem.mem[d+i], 32'hC0DE_0000 + 32'(s + i));
    end
    chk({29'h0, u_mem.mem[c*4+2][2:0]}, 32'h0);
  endtask : cpy
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axr(`DCA_A_FLAGS, d, r);
    chk(d, 32'h0);
    axr(8'h3C, d, r);
    chk({30'h0, r}, {30'h0, `DCA_RESP_ERR});
    axw(8'h3C, 32'h1, `DCA_RESP_ERR);
    axw(`DCA_A_BASE, 32'h0);
    axw(`DCA_A_CH_EN, 32'hF);
    axr(`DCA_A_CH_EN, d, r);
    chk(d, 32'hF);
    axw(8'h08, 32'hFFFF_FFFF);
    axr(8'h08, d, r);
    chk(d, `DCA_CTRL_MASK);
  endtask : t_regs
  task automatic t_basic();
    logic [31:0] d;
    logic [1:0] r;
    desc(0, 16, 32, 2, 1, `DCA_CYC_BASIC);
    axw(`DCA_A_SW_REQ, 32'h1);
    wdone(0);
    cpy(0, 16, 32, 2);
    axr(`DCA_A_FLAGS, d, r);
    chk(d, 32'h1);
    axw(`DCA_A_FLAGS, 32'h1);
    axr(`DCA_A_FLAGS, d, r);
    chk(d, 32'h0);
  endtask : t_basic
  // Auto-request runs three words in bursts of two: one full, one leftover
  task automatic t_types();
    int n;
    for (int y = 1; y < 8; y++) begin
      n = (y == 2) ? 3 : 1;
      lat <= y[0] ? 4'h3 : 4'h0;
      desc(1, 16 + y, 48 + y, n, n / 3, 3'(y));
      axw(`DCA_A_SW_REQ, 32'h2);
      wdone(1);
      cpy(1, 16 + y, 48 + y, n);
    end
  endtask : t_types
  task automatic t_prio();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 2; p++) begin
      axw(p ? `DCA_A_PRIO_SET : `DCA_A_PRIO_CLR, 32'h8);
      desc(0, 24, 40, 1, 0, `DCA_CYC_BASIC);
      desc(3, 28, 44, 1, 0, `DCA_CYC_BASIC);
      axw(`DCA_A_SW_REQ, 32'h9);
      for (n = 0; n < 3000 && chan_done == 4'h0; n++) @(posedge aclk);
      if (n == 3000) hang();
      chk({28'h0, chan_done}, p ? 32'h8 : 32'h1);
      wdone(p ? 0 : 3);
    end
    axr(`DCA_A_PRIO_SET, d, r);
    chk(d, 32'h8);
    axw(`DCA_A_PRIO_CLR, 32'h8);
  endtask : t_prio
  task automatic t_lock();
    logic [31:0] d;
    logic [1:0] r;
    desc(2, 16, 56, 1, 0, `DCA_CYC_INVALID);
    axw(`DCA_A_SW_REQ, 32'h4);
    for (int i = 0; i < 20; i++) begin
      axr(`DCA_A_STATUS, d, r);
      if (d[14]) break;
    end
    chk({31'h0, d[14]}, 32'h1);
    chk(u_mem.mem[56], 32'hC0DE_0038);
    axr(`DCA_A_FLAGS, d, r);
    chk({31'h0, d[2]}, 32'h0);
    axw(8'h08, 32'h0);
    axr(`DCA_A_STATUS, d, r);
    chk({31'h0, d[14]}, 32'h0);
  endtask : t_lock
  // A held request refetches the invalidated descriptor and locks out,
  // so wait for that before loading the next one
  task automatic t_periph();
    logic [31:0] d;
    logic [1:0] r;
    logic seen;
    axw(8'h00, 32'h0000_0102);
    desc(0, 26, 42, 4, 1, `DCA_CYC_BASIC);
    periph_burst_req[8] <= 1'b1;
    periph_single_req[9] <= 1'b1;
    seen = 1'b0;
    repeat (40) @(posedge aclk) seen = seen | mem_req;
    chk({31'h0, seen}, 32'h0);
    periph_burst_req[9] <= 1'b1;
    wdone(0);
    for (int i = 0; i < 20; i++) begin
      axr(`DCA_A_STATUS, d, r);
      if (d[12]) break;
    end
    chk({31'h0, d[12]}, 32'h1);
    periph_burst_req <= 64'h0;
    cpy(0, 26, 42, 4);
    desc(0, 30, 46, 1, 0, `DCA_CYC_BASIC);
    axr(`DCA_A_STATUS, d, r);
    axw(8'h00, 32'h0001_0102);
    wdone(0);
    periph_single_req <= 64'h0;
    cpy(0, 30, 46, 1);
  endtask : t_periph
  initial begin
    failures = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    periph_burst_req = 64'h0;
    periph_single_req = 64'h0;
    lat = 4'h0;
    for (int i = 0; i < 64; i++) u_mem.mem[i] = 32'hC0DE_0000 + 32'(i);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_basic();
    t_types();
    t_prio();
    t_lock();
    t_periph();
    final_report();
  end
endmodule : dca_top_bench
